// File: design/titr_pkg.sv
// constants, register map and field layout of the trace integration-test registers
//------------------------------------------------------------
// Behaviour
// RQ1 - output drive only while integration mode set
// RQ2 - input readback live while integration mode set
// RQ3 - misc out bits 9:8 drive event outputs
// RQ4 - misc in bits 3:0 return event inputs
// RQ5 - trigger bit 0 drives trigger output
// RQ6 - data bits 4..0 drive bus bits 31,23,15,7,0
// RQ7 - reserved bits read zero, writes ignored
// RQ8 - control readback: flush valid bit1, ready bit0
// RQ9 - integration mode bit clears on reset
// RQ10 - software resets unit after leaving integration mode
//------------------------------------------------------------
package titr_pkg;
	localparam int          ADDR_W          = 12;
	localparam int          DATA_W          = 32;
	localparam int          TDATA_W         = 32;
	// register byte addresses
	localparam logic [11:0] ADDR_MISC_OUT   = 12'hEDC;
	localparam logic [11:0] ADDR_MISC_IN    = 12'hEE0;
	localparam logic [11:0] ADDR_TRIGGER    = 12'hEE8;
	localparam logic [11:0] ADDR_TDATA      = 12'hEEC;
	localparam logic [11:0] ADDR_CTRL_RB    = 12'hEF0;
	localparam logic [11:0] ADDR_MODE_CTRL  = 12'hF00;
	// field positions
	localparam int          MODE_BIT        = 0;
	localparam int          EVOUT_LSB       = 8;
	localparam int          EVOUT_W         = 2;
	localparam int          EVIN_W          = 4;
	localparam int          TRIG_BIT        = 0;
	localparam int          TDSEL_W         = 5;
	localparam int          RB_READY_BIT    = 0;
	localparam int          RB_FLUSH_BIT    = 1;
	localparam logic [31:0] ZERO_WORD       = 32'h0000_0000;
	// bus bit fed by each data drive bit, register bit 4 first
	localparam logic [TDSEL_W-1:0][4:0] TD_BIT_POS = {5'h1F, 5'h17, 5'h0F, 5'h07, 5'h00};
	localparam logic [31:0] TD_USED_MASK    = 32'h8080_8081;
endpackage

// File: design/titr_regs.sv
// integration-test register set of the program trace unit
`timescale 1ns/1ps
module titr_regs
	import titr_pkg::*;
(
	// clock and reset
	input  wire logic               CLOCK,
	input  wire logic               RST,
	// register port
	input  wire logic [ADDR_W-1:0]  ADDR,
	input  wire logic [DATA_W-1:0]  WDATA,
	input  wire logic               WR,
	input  wire logic               RD,
	output logic      [DATA_W-1:0]  RDATA,
	// normal trace logic side
	input  wire logic [EVOUT_W-1:0] NORM_EVENT_OUT,
	input  wire logic               NORM_TRIGGER,
	input  wire logic [TDATA_W-1:0] NORM_TDATA,
	// pins
	input  wire logic [EVIN_W-1:0]  TRACE_EVENT_INPUTS,
	input  wire logic               TRACE_FLUSH_VALID_IN,
	input  wire logic               TRACE_BUS_READY_IN,
	output logic [EVOUT_W-1:0]      TRACE_EVENT_OUTPUTS,
	output logic                    TRACE_TRIGGER_OUTPUT,
	output logic [TDATA_W-1:0]      TRACE_BUS_DATA_OUT,
	output logic                    INTEGRATION_MODE
);
	//------------------------------------------------------------
	// registers
	//------------------------------------------------------------
	logic               mode_r;
	logic [EVOUT_W-1:0] evout_r;
	logic               trig_r;
	logic [TDSEL_W-1:0] tdsel_r;
	logic [DATA_W-1:0]  rdata_nxt;
	logic [TDATA_W-1:0] tdata_nxt;

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
		return a == r;
	endfunction

	// mode bit, cleared on reset so only software enters test mode
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			mode_r <= 1'b0; // [RQ9]
		end else if (WR && hit(ADDR, ADDR_MODE_CTRL)) begin
			mode_r <= WDATA[MODE_BIT];
		end
	end

	// drive registers keep only their defined bits
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			evout_r <= '0;
			trig_r  <= 1'b0;
			tdsel_r <= '0;
		end else if (WR) begin
			if (hit(ADDR, ADDR_MISC_OUT)) evout_r <= WDATA[EVOUT_LSB +: EVOUT_W]; // [RQ3] [RQ7]
			if (hit(ADDR, ADDR_TRIGGER))  trig_r  <= WDATA[TRIG_BIT];             // [RQ5] [RQ7]
			if (hit(ADDR, ADDR_TDATA))    tdsel_r <= WDATA[TDSEL_W-1:0];          // [RQ6] [RQ7]
		end
	end

	//------------------------------------------------------------
	// read path
	//------------------------------------------------------------
	// read mux; drive registers are write only and unmapped reads give zero
	always_comb begin
		rdata_nxt = ZERO_WORD; // [RQ7]
		if (hit(ADDR, ADDR_MODE_CTRL)) rdata_nxt[MODE_BIT] = mode_r;
		if (mode_r) begin // [RQ2]
			if (hit(ADDR, ADDR_MISC_IN)) rdata_nxt[EVIN_W-1:0] = TRACE_EVENT_INPUTS; // [RQ4]
			if (hit(ADDR, ADDR_CTRL_RB)) begin
				rdata_nxt[RB_FLUSH_BIT] = TRACE_FLUSH_VALID_IN; // [RQ8]
				rdata_nxt[RB_READY_BIT] = TRACE_BUS_READY_IN;   // [RQ8]
			end
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge CLOCK) begin
		if (RST) RDATA <= ZERO_WORD;
		else if (RD) RDATA <= rdata_nxt;
		else RDATA <= ZERO_WORD;
	end

	//------------------------------------------------------------
	// pin drive
	//------------------------------------------------------------
	// output steering between test registers and normal trace logic
	always_comb begin
		tdata_nxt     = NORM_TDATA;
		if (mode_r) begin // [RQ1]
			tdata_nxt     = '0;
			for (int i = 0; i < TDSEL_W; i++) begin
				tdata_nxt[TD_BIT_POS[i]] = tdsel_r[i]; // [RQ6]
			end
		end
	end

	// registered pins, one cycle behind their source
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			TRACE_EVENT_OUTPUTS  <= '0;
			TRACE_TRIGGER_OUTPUT <= 1'b0;
			TRACE_BUS_DATA_OUT   <= '0;
			INTEGRATION_MODE     <= 1'b0;
		end else begin
			TRACE_EVENT_OUTPUTS  <= mode_r ? evout_r : NORM_EVENT_OUT; // [RQ1] [RQ3]
			TRACE_TRIGGER_OUTPUT <= mode_r ? trig_r : NORM_TRIGGER;    // [RQ1] [RQ5]
			TRACE_BUS_DATA_OUT   <= tdata_nxt;
			INTEGRATION_MODE     <= mode_r;
		end
	end

	//------------------------------------------------------------
	// assertions
	//------------------------------------------------------------
	sequence s_trig_write;
		WR && hit(ADDR, ADDR_TRIGGER) && mode_r;
	endsequence
	property p_trig_drive;
		@(posedge CLOCK) disable iff (RST) s_trig_write ##1 mode_r |=> TRACE_TRIGGER_OUTPUT == $past(WDATA[TRIG_BIT], 2);
	endproperty
	a_trig_drive: assert property (p_trig_drive) else $error("trigger not driven"); // [RQ5]
	property p_norm_pass;
		@(posedge CLOCK) disable iff (RST) !RST && !mode_r |=> TRACE_EVENT_OUTPUTS == $past(NORM_EVENT_OUT);
	endproperty
	a_norm_pass: assert property (p_norm_pass) else $error("normal events not passed"); // [RQ1]
	property p_evout;
		@(posedge CLOCK) disable iff (RST) mode_r |=> TRACE_EVENT_OUTPUTS == $past(evout_r);
	endproperty
	a_evout: assert property (p_evout) else $error("event outputs wrong"); // [RQ3]
	property p_tdata;
		@(posedge CLOCK) disable iff (RST) mode_r |=> TRACE_BUS_DATA_OUT[31] == $past(tdsel_r[4]) &&
			TRACE_BUS_DATA_OUT[0] == $past(tdsel_r[0]) && TRACE_BUS_DATA_OUT[7] == $past(tdsel_r[1]) &&
			TRACE_BUS_DATA_OUT[15] == $past(tdsel_r[2]) && TRACE_BUS_DATA_OUT[23] == $past(tdsel_r[3]) &&
			(TRACE_BUS_DATA_OUT & ~TD_USED_MASK) == ZERO_WORD;
	endproperty
	a_tdata: assert property (p_tdata) else $error("data bits wrong"); // [RQ6]
	property p_evin;
		@(posedge CLOCK) disable iff (RST) RD && mode_r && hit(ADDR, ADDR_MISC_IN) |=>
			RDATA == (ZERO_WORD | DATA_W'($past(TRACE_EVENT_INPUTS)));
	endproperty
	a_evin: assert property (p_evin) else $error("event input readback wrong"); // [RQ4]
	property p_ctrl_rb;
		@(posedge CLOCK) disable iff (RST) RD && mode_r && hit(ADDR, ADDR_CTRL_RB) |=>
			RDATA == (ZERO_WORD | (DATA_W'($past(TRACE_FLUSH_VALID_IN)) << RB_FLUSH_BIT)
				| (DATA_W'($past(TRACE_BUS_READY_IN)) << RB_READY_BIT));
	endproperty
	a_ctrl_rb: assert property (p_ctrl_rb) else $error("control readback wrong"); // [RQ8]
	property p_wo_zero;
		@(posedge CLOCK) disable iff (RST) RD && (hit(ADDR, ADDR_TRIGGER) || hit(ADDR, ADDR_TDATA)) |=> RDATA == ZERO_WORD;
	endproperty
	a_wo_zero: assert property (p_wo_zero) else $error("reserved read not zero"); // [RQ7]
	property p_rst_mode;
		@(posedge CLOCK) RST |=> !mode_r && !INTEGRATION_MODE;
	endproperty
	a_rst_mode: assert property (p_rst_mode) else $error("mode not cleared by reset"); // [RQ9]
	property p_live_off;
		@(posedge CLOCK) disable iff (RST) RD && !mode_r && hit(ADDR, ADDR_MISC_IN) |=> RDATA == ZERO_WORD;
	endproperty
	a_live_off: assert property (p_live_off) else $error("readback live outside mode"); // [RQ2]
	// pass-through of the normal trace side while the mode bit is clear
	property p_trig_norm;
		@(posedge CLOCK) disable iff (RST) !RST && !mode_r |=> TRACE_TRIGGER_OUTPUT == $past(NORM_TRIGGER);
	endproperty
	a_trig_norm: assert property (p_trig_norm) else $error("normal trigger not passed"); // [RQ1]
	property p_tdata_norm;
		@(posedge CLOCK) disable iff (RST) !RST && !mode_r |=> TRACE_BUS_DATA_OUT == $past(NORM_TDATA);
	endproperty
	a_tdata_norm: assert property (p_tdata_norm) else $error("normal data not passed"); // [RQ1]
	// a mode write lands in the register, then on the mode output
	sequence s_mode_write;
		WR && hit(ADDR, ADDR_MODE_CTRL);
	endsequence
	sequence s_mode_follow;
		mode_r == $past(WDATA[MODE_BIT]) ##1 INTEGRATION_MODE == $past(WDATA[MODE_BIT], 2);
	endsequence
	property p_mode_write;
		@(posedge CLOCK) disable iff (RST) s_mode_write |=> s_mode_follow;
	endproperty
	a_mode_write: assert property (p_mode_write) else $error("mode write not applied"); // [RQ1]
	// a misc write in mode reaches the event pins two edges later
	sequence s_evout_write;
		WR && hit(ADDR, ADDR_MISC_OUT) && mode_r;
	endsequence
	property p_evout_write;
		@(posedge CLOCK) disable iff (RST) s_evout_write ##1 mode_r |=>
			TRACE_EVENT_OUTPUTS == $past(WDATA[EVOUT_LSB +: EVOUT_W], 2);
	endproperty
	a_evout_write: assert property (p_evout_write) else $error("event write not driven"); // [RQ3]
	// a data write in mode reaches the five bus bits two edges later
	sequence s_tdata_write;
		WR && hit(ADDR, ADDR_TDATA) && mode_r;
	endsequence
	property p_tdata_write;
		@(posedge CLOCK) disable iff (RST) s_tdata_write ##1 mode_r |=>
			TRACE_BUS_DATA_OUT[31] == $past(WDATA[4], 2) && TRACE_BUS_DATA_OUT[23] == $past(WDATA[3], 2) &&
			TRACE_BUS_DATA_OUT[15] == $past(WDATA[2], 2) && TRACE_BUS_DATA_OUT[7] == $past(WDATA[1], 2) &&
			TRACE_BUS_DATA_OUT[0] == $past(WDATA[0], 2);
	endproperty
	a_tdata_write: assert property (p_tdata_write) else $error("data write not driven"); // [RQ6]
	// mode bit reads back, every other bit of that word reads zero
	property p_mode_rb;
		@(posedge CLOCK) disable iff (RST) RD && hit(ADDR, ADDR_MODE_CTRL) |=>
			RDATA == (ZERO_WORD | (DATA_W'($past(mode_r)) << MODE_BIT));
	endproperty
	a_mode_rb: assert property (p_mode_rb) else $error("mode readback wrong"); // [RQ7]
	// trace-bus readback stays dark outside integration mode
	property p_ctrl_off;
		@(posedge CLOCK) disable iff (RST) RD && !mode_r && hit(ADDR, ADDR_CTRL_RB) |=> RDATA == ZERO_WORD;
	endproperty
	a_ctrl_off: assert property (p_ctrl_off) else $error("control readback live outside mode"); // [RQ2]
	// the misc drive register is write only as well
	property p_wo_misc;
		@(posedge CLOCK) disable iff (RST) RD && hit(ADDR, ADDR_MISC_OUT) |=> RDATA == ZERO_WORD;
	endproperty
	a_wo_misc: assert property (p_wo_misc) else $error("write-only read not zero"); // [RQ7]
	// every pin sits low in the cycle after a reset edge
	property p_rst_pins;
		@(posedge CLOCK) RST |=> TRACE_EVENT_OUTPUTS == '0 && !TRACE_TRIGGER_OUTPUT &&
			TRACE_BUS_DATA_OUT == '0;
	endproperty
	a_rst_pins: assert property (p_rst_pins) else $error("pins not cleared by reset"); // [RQ9]
endmodule

// File: tb/titr_far_end.sv
// far-side model: trace sink and cross-trigger levels
`timescale 1ns/1ps
module titr_far_end (
	// clock and commanded levels
	input  wire logic       clock,
	input  wire logic [5:0] pat,
	// levels toward the trace unit
	output logic [3:0]      ev_in,
	output logic            flush_valid,
	output logic            ready
);
	// levels move just after an edge, as real sink logic would
	always_ff @(posedge clock) begin
		{flush_valid, ready, ev_in} <= pat;
	end
endmodule

// File: tb/testbench.sv
// register-level test of the integration-test registers
`timescale 1ns/1ps
module testbench import titr_pkg::*;;
	logic        clock = 0, rst = 1, wr = 0, rd = 0, trig, imode, fv, rdy;
	logic [11:0] addr = 12'h000;
	logic [31:0] wdata = 32'h0, rdata, tdo;
	logic [5:0]  pat = 6'h3F;
	logic [3:0]  evi;
	logic [1:0]  evo;
	logic [1:0]  nev = 2'h1;
	logic        ntrig = 1'h1;
	logic [31:0] ntd = 32'h1234_5678;
	int          n_mismatch = 0, checks_done = 0, cyc = 0;
	int          pos[5] = '{0, 7, 15, 23, 31};
	titr_far_end far (.clock(clock), .pat(pat), .ev_in(evi), .flush_valid(fv), .ready(rdy));
	titr_regs dut (.CLOCK(clock), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
		.NORM_EVENT_OUT(nev), .NORM_TRIGGER(ntrig), .NORM_TDATA(ntd),
		.TRACE_EVENT_INPUTS(evi), .TRACE_FLUSH_VALID_IN(fv), .TRACE_BUS_READY_IN(rdy),
		.TRACE_EVENT_OUTPUTS(evo), .TRACE_TRIGGER_OUTPUT(trig), .TRACE_BUS_DATA_OUT(tdo), .INTEGRATION_MODE(imode));
	// 4 ns clock; ceiling far above the sequence length
	initial forever #2 clock = ~clock;
	always @(posedge clock) begin
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			$display("BAD %0t timeout", $time);
			close_out;
		end
	end
	// ----
	// tasks
	// ----
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		{wr, addr, wdata} <= {1'b1, a, d};
		@(posedge clock);
		wr <= 1'b0;
		repeat (3) @(posedge clock);
		#1;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
		@(posedge clock);
		{rd, addr} <= {1'b1, a};
		@(posedge clock);
		rd <= 1'b0;
		#1 chk(rdata, e);
	endtask
	task automatic close_out;
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// ----
	// sequence
	// ----
	initial begin
		repeat (5) @(posedge clock);
		rst <= 1'h0;
		repeat (3) @(posedge clock);
		#1 chk(32'({imode, trig, evo}), 32'h5);
		chk(tdo, 32'h1234_5678);
		rd_chk(ADDR_MODE_CTRL, 32'h0);
		rd_chk(ADDR_MISC_IN, 32'h0);
		rd_chk(ADDR_CTRL_RB, 32'h0);
		wr_reg(ADDR_MODE_CTRL, 32'h1);
		chk(32'({imode, trig, evo}), 32'h8);
		chk(tdo, 32'h0);
		rd_chk(ADDR_MODE_CTRL, 32'h1);
		wr_reg(ADDR_MISC_OUT, 32'h0000_0300);
		chk(32'(evo), 32'h3);
		wr_reg(ADDR_MISC_OUT, 32'hFFFF_FCFF);
		chk(32'(evo), 32'h0);
		wr_reg(ADDR_MISC_OUT, 32'h0000_0200);
		chk(32'(evo), 32'h2);
		wr_reg(ADDR_TRIGGER, 32'hFFFF_FFFF);
		chk(32'(trig), 32'h1);
		wr_reg(ADDR_TRIGGER, 32'hFFFF_FFFE);
		chk(32'(trig), 32'h0);
		for (int i = 0; i < 5; i++) begin
			wr_reg(ADDR_TDATA, 32'h1 << i);
			chk(tdo, 32'h1 << pos[i]);
		end
		wr_reg(ADDR_TDATA, 32'h0000_001F);
		chk(tdo, 32'h8080_8081);
		rd_chk(ADDR_TDATA, 32'h0);
		wr_reg(ADDR_TDATA, 32'hFFFF_FFE0);
		chk(tdo, 32'h0);
		rd_chk(ADDR_MISC_OUT, 32'h0);
		rd_chk(12'h004, 32'h0);
		for (int i = 0; i < 16; i++) begin
			pat <= 6'(i);
			rd_chk(ADDR_MISC_IN, 32'(i));
		end
		for (int i = 0; i < 4; i++) begin
			pat <= {2'(i), 4'hF};
			rd_chk(ADDR_CTRL_RB, 32'(i));
		end
		// move the normal side so that pass-through is seen to follow it
		@(posedge clock);
		{nev, ntd} <= {2'h3, 32'hA5C3_0F96};
		wr_reg(ADDR_MODE_CTRL, 32'h0);
		chk(32'({imode, trig, evo}), 32'h7);
		chk(tdo, 32'hA5C3_0F96);
		rd_chk(ADDR_MISC_IN, 32'h0);
		@(posedge clock);
		rst <= 1'h1;
		repeat (2) @(posedge clock);
		rst <= 1'h0;
		rd_chk(ADDR_MODE_CTRL, 32'h0);
		// reset while in integration mode must drop the mode and the drive registers
		wr_reg(ADDR_MODE_CTRL, 32'h1);
		chk(32'({imode, trig, evo}), 32'h8);
		@(posedge clock);
		rst <= 1'h1;
		repeat (2) @(posedge clock);
		rst <= 1'h0;
		#1 chk(32'({imode, trig, evo}), 32'h0);
		rd_chk(ADDR_MODE_CTRL, 32'h0);
		chk(tdo, 32'hA5C3_0F96);
		close_out;
	end
endmodule
